// file: design/mra_pkg.sv
package mra_pkg;
   // ==================================================
   // Result layout
   localparam int N_PERIODS = 3;
   localparam int N_FIELDS = 10;
   localparam int F_PREV = 3;
   localparam int F_CUM = 6;
   localparam int F_CUMCUR = 9;
   // ==================================================
   // Filter settings
   localparam logic [2:0] FILTER_NULL = 3'h0;
   localparam logic [2:0] FILTER_BIN_UP_SIGNED = 3'h1;
   localparam logic [2:0] FILTER_BIN_UP_NONNEG = 3'h2;
   localparam logic [2:0] FILTER_BIN_UPDOWN_SIGNED = 3'h3;
   localparam logic [2:0] FILTER_BIN_UPDOWN_NONNEG = 3'h4;
   localparam logic [2:0] FILTER_DEC_UP_NONNEG = 3'h5;
   localparam logic [2:0] FILTER_DEC_UPDOWN_NONNEG = 3'h6;
   // One above the decimal maximum 999999999
   localparam logic signed [33:0] DEC_SPAN = 34'sh3B9ACA00;
   // ==================================================
   // Register map
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_SERIAL = 12'h080;
   localparam logic [11:0] ADDR_CFG = 12'h100;
   localparam logic [11:0] ADDR_RES = 12'h400;
   localparam logic [11:0] ADDR_RES9 = 12'h800;
   localparam int RES_STRIDE = 16;
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_END_LSB = 4;
   localparam int CFG_SIGN_BIT = 8;
   localparam int CFG_TYPE_LSB = 16;
   localparam int CFG_SELB_LSB = 8;
   localparam int PEND_W = 8;
   localparam logic RST_HREADYOUT = 1'b1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// file: design/mra_filter.sv
`timescale 1ns/100ps
module mra_filter (
   // Filter setting
   input wire logic [2:0] ftype,
   // Stored value and incoming change
   input wire logic [31:0] value,
   input wire logic [31:0] delta,
   // Updated value and change let through
   output logic [31:0] result,
   output logic [31:0] passed
);
   logic signed [33:0] sum;
   logic up_only;

   always_comb begin
      up_only = ftype == mra_pkg::FILTER_BIN_UP_SIGNED ||
         ftype == mra_pkg::FILTER_BIN_UP_NONNEG ||
         ftype == mra_pkg::FILTER_DEC_UP_NONNEG;
      if (ftype == mra_pkg::FILTER_NULL || (up_only && delta[31])) begin
         passed = '0;
      end else begin
         passed = delta;
      end
      sum = $signed({{2{value[31]}}, value}) +
         $signed({{2{passed[31]}}, passed});
      case (ftype)
         mra_pkg::FILTER_BIN_UP_SIGNED,
         mra_pkg::FILTER_BIN_UPDOWN_SIGNED: begin
            result = sum[31:0];
         end
         mra_pkg::FILTER_BIN_UP_NONNEG,
         mra_pkg::FILTER_BIN_UPDOWN_NONNEG: begin
            result = {1'b0, sum[30:0]};
         end
         mra_pkg::FILTER_DEC_UP_NONNEG,
         mra_pkg::FILTER_DEC_UPDOWN_NONNEG: begin
            if (sum >= mra_pkg::DEC_SPAN) begin
               result = 32'(sum - mra_pkg::DEC_SPAN);
            end else if (sum[33]) begin
               result = 32'(sum + mra_pkg::DEC_SPAN);
            end else begin
               result = sum[31:0];
            end
         end
         default: begin
            result = value;
         end
      endcase
   end
endmodule

// file: design/mra_accumulator.sv
// What this block does
// - A level 0-2 result has ten fields: per-period and total values.
// - Levels below 9 keep three measuring periods in parallel.
// - Period end copies that period's current field into its previous field.
// - Then that previous value is added into its cumulative field.
// - Finally that period's current field is cleared.
// - Level-9 results ignore measuring periods and period ends.
// - Each result has its own filter; null filter leaves it unchanged.
// - Signed binary up: positive changes only, 32-bit signed wrap.
// - Non-negative binary up: positive changes only, wraps to zero at 2^31.
// - Signed binary up/down: both directions, wraps at both ends.
// - Non-negative binary up/down: both directions within 0..2^31-1, wraps.
// - Decimal up: positive only, 0..999999999, wraps to zero.
// - Decimal up/down: both directions within 0..999999999, wraps both ways.
// - Per impulse, quotient of remainder plus a over b is the conversion.
// - Only the whole quotient counts; remainder is kept per result.
// - Each level-0 result converts alone, impulse or serial source alike.
// - A per-result sign makes converted changes positive or negative.
// - Level-1 sums add selected level-0 results, each at most once.
// - Level-2 functions take inputs from level-0 or level-1 results.
// - Level-9 rescales a lower result by an integer fraction.
// - Sum membership is one bit per level-0 result, eight per byte.
// - Level-2 change is d/e times A plus f/g times B.
`timescale 1ns/100ps
module mra_accumulator #(
   parameter int N0 = 4,
   parameter int N1 = 2,
   parameter int N2 = 2,
   parameter int N9 = 2
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Meter impulse and period end pins
   input wire logic [N0-1:0] in_pulse,
   input wire logic [mra_pkg::N_PERIODS-1:0] period_end,
   // Level-9 change strobes
   output logic [N9-1:0] l9_pulse
);
   // ==================================================
   // Sizes and configuration word positions
   localparam int NR = N0 + N1 + N2;
   localparam int W_L1 = 2 * N0;
   localparam int W_L2 = W_L1 + 2 * N1;
   localparam int W_L9 = W_L2 + 3 * N2;
   localparam int NCFG = W_L9 + 2 * N9;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONVERT = 2'b01,
      ST_ROLL = 2'b10
   } mra_state_t;

   typedef struct packed {
      mra_state_t state;
      logic enable;
      logic [mra_pkg::N_PERIODS-1:0] roll;
      logic [NCFG-1:0][31:0] cfg;
      logic [N0-1:0][mra_pkg::PEND_W-1:0] pend;
      logic [N0-1:0][15:0] rem;
      logic [NR-1:0][mra_pkg::N_FIELDS-1:0][31:0] res;
      logic [N9-1:0][31:0] res9;
      logic [N9-1:0][31:0] rem9;
      logic [N0-1:0] in_s1;
      logic [N0-1:0] in_s2;
      logic [N0-1:0] in_last;
      logic [mra_pkg::N_PERIODS-1:0] pe_s1;
      logic [mra_pkg::N_PERIODS-1:0] pe_s2;
      logic [mra_pkg::N_PERIODS-1:0] pe_last;
      logic dp_wr;
      logic [11:0] dp_addr;
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
      logic [N9-1:0] l9_pulse;
   } mra_regs_t;

   mra_regs_t r;
   mra_regs_t n;
   logic [31:0] delta_r [NR];
   logic [31:0] nv [NR][4];
   logic [NR-1:0][31:0] pass_p;
   logic [N0-1:0] go0;
   logic [N0-1:0][15:0] rem0;
   logic [N9-1:0][31:0] nv9;
   logic [N9-1:0][31:0] pass9;
   logic [N9-1:0][31:0] rem9n;
   logic acc;
   logic [mra_pkg::N_PERIODS-1:0] roll_set;
   logic [mra_pkg::N_PERIODS-1:0] roll_clr;
   logic [9:0] p;
   logic [9:0] wres;
   logic [31:0] rd;

   // ==================================================
   // Helpers
   function automatic logic [31:0] pick(
      input logic [NR-1:0][31:0] v,
      input logic [7:0] sel,
      input int lim
   );
      if (int'(sel) < lim) begin
         return v[sel];
      end
      return '0;
   endfunction

   function automatic logic [31:0] masked_sum(
      input logic [31:0] mask,
      input logic [N0-1:0][31:0] v
   );
      logic [31:0] s;
      s = '0;
      for (int i = 0; i < N0; i++) begin
         if (mask[i]) begin
            s = s + v[i];
         end
      end
      return s;
   endfunction

   function automatic logic in_reg(
      input logic [11:0] a,
      input logic [11:0] base,
      input int words
   );
      return int'(a) >= int'(base) && int'(a) < int'(base) + 4 * words;
   endfunction

   function automatic logic [9:0] word_of(
      input logic [11:0] a,
      input logic [11:0] base
   );
      return 10'((a - base) >> 2);
   endfunction

   // ==================================================
   // Level 0: impulse conversion with carried remainder
   for (genvar i = 0; i < N0; i++) begin : g_l0
      logic [16:0] sum;
      logic [16:0] den;
      logic [16:0] quo;
      logic [15:0] rm;
      logic [31:0] dl;
      always_comb begin
         sum = {1'b0, r.rem[i]} + {1'b0, r.cfg[2*i][15:0]};
         den = {1'b0, r.cfg[2*i][31:16]};
         if (den == '0) begin
            den = 17'h00001;
         end
         quo = sum / den;
         rm = 16'(sum % den);
         if (r.cfg[2*i+1][mra_pkg::CFG_SIGN_BIT]) begin
            dl = -32'(quo);
         end else begin
            dl = 32'(quo);
         end
      end
      assign go0[i] = r.state == ST_CONVERT && r.pend[i] != '0;
      assign rem0[i] = rm;
      assign delta_r[i] = go0[i] ? dl : '0;
   end

   // ==================================================
   // Level 1: masked sums
   for (genvar j = 0; j < N1; j++) begin : g_l1
      assign delta_r[N0+j] =
         masked_sum(r.cfg[W_L1+2*j], pass_p[N0-1:0]);
   end

   // ==================================================
   // Level 2: two-term fraction functions
   for (genvar k = 0; k < N2; k++) begin : g_l2
      localparam int W = W_L2 + 3 * k;
      logic signed [48:0] ta;
      logic signed [48:0] tb;
      logic signed [48:0] de;
      logic signed [48:0] dg;
      logic [31:0] dl;
      always_comb begin
         de = 49'($signed(r.cfg[W][31:16]));
         dg = 49'($signed(r.cfg[W+1][31:16]));
         if (de == '0) begin
            de = 49'sd1;
         end
         if (dg == '0) begin
            dg = 49'sd1;
         end
         ta = 49'($signed(r.cfg[W][15:0])) * 49'($signed(
            pick(pass_p, r.cfg[W+2][7:0], N0 + N1)));
         tb = 49'($signed(r.cfg[W+1][15:0])) * 49'($signed(
            pick(pass_p, r.cfg[W+2][mra_pkg::CFG_SELB_LSB+:8], N0 + N1)));
         dl = 32'(ta / de + tb / dg);
      end
      assign delta_r[N0+N1+k] = dl;
   end

   // ==================================================
   // Result filters on the three current fields and the total
   for (genvar x = 0; x < NR; x++) begin : g_res
      localparam int TW = x < N0 ? 2 * x + 1 :
         (x < N0 + N1 ? W_L1 + 2 * (x - N0) + 1 :
         W_L2 + 3 * (x - N0 - N1) + 2);
      localparam int TL = x < N0 + N1 ? 0 : mra_pkg::CFG_TYPE_LSB;
      for (genvar f = 0; f < mra_pkg::N_PERIODS; f++) begin : g_cur
         mra_filter u_filt (
            .ftype(r.cfg[TW][TL+:3]),
            .value(r.res[x][f]),
            .delta(delta_r[x]),
            .result(nv[x][f]),
            .passed()
         );
      end
      mra_filter u_total (
         .ftype(r.cfg[TW][TL+:3]),
         .value(r.res[x][mra_pkg::F_CUMCUR]),
         .delta(delta_r[x]),
         .result(nv[x][3]),
         .passed(pass_p[x])
      );
   end

   // ==================================================
   // Level 9: rescaling to the external impulse value
   for (genvar q = 0; q < N9; q++) begin : g_l9
      localparam int W = W_L9 + 2 * q;
      logic signed [48:0] num;
      logic signed [48:0] den;
      logic [31:0] dq;
      logic [31:0] rq;
      always_comb begin
         den = {33'h0, r.cfg[W][31:16]};
         if (den == '0) begin
            den = 49'sd1;
         end
         num = 49'($signed(r.rem9[q])) +
            49'($signed({1'b0, r.cfg[W][15:0]})) *
            49'($signed(pick(pass_p, r.cfg[W+1][7:0], NR)));
         dq = 32'(num / den);
         rq = 32'(num % den);
      end
      assign rem9n[q] = rq;
      mra_filter u_filt (
         .ftype(r.cfg[W+1][mra_pkg::CFG_TYPE_LSB+:3]),
         .value(r.res9[q]),
         .delta(dq),
         .result(nv9[q]),
         .passed(pass9[q])
      );
   end

   // ==================================================
   // Next state
   always_comb begin
      n = r;
      roll_set = r.pe_s2 & ~r.pe_last;
      roll_clr = '0;
      p = '0;
      n.in_s1 = in_pulse;
      n.in_s2 = r.in_s1;
      n.in_last = r.in_s2;
      n.pe_s1 = period_end;
      n.pe_s2 = r.pe_s1;
      n.pe_last = r.pe_s2;

      // Bus address phase and read data
      acc = hsel && htrans[1] && hready;
      n.dp_wr = acc && hwrite && hsize == mra_pkg::HSIZE_WORD;
      if (acc) begin
         n.dp_addr = haddr;
      end
      n.hreadyout = 1'b1;
      n.hresp = 1'b0;
      wres = word_of(haddr, mra_pkg::ADDR_RES);
      rd = '0;
      if (haddr == mra_pkg::ADDR_CTRL) begin
         rd[mra_pkg::CTRL_ENABLE] = r.enable;
      end else if (haddr == mra_pkg::ADDR_STATUS) begin
         rd = {23'h0, |r.pend, 1'b0, r.roll, 3'h0, r.state != ST_IDLE};
      end else if (in_reg(haddr, mra_pkg::ADDR_SERIAL, N0)) begin
         rd = 32'(r.pend[word_of(haddr, mra_pkg::ADDR_SERIAL)]);
      end else if (in_reg(haddr, mra_pkg::ADDR_CFG, NCFG)) begin
         rd = r.cfg[word_of(haddr, mra_pkg::ADDR_CFG)];
      end else if (in_reg(haddr, mra_pkg::ADDR_RES,
            mra_pkg::RES_STRIDE * NR) &&
            int'(wres[3:0]) < mra_pkg::N_FIELDS) begin
         rd = r.res[wres[9:4]][wres[3:0]];
      end else if (in_reg(haddr, mra_pkg::ADDR_RES9, N9)) begin
         rd = r.res9[word_of(haddr, mra_pkg::ADDR_RES9)];
      end
      if (acc && !hwrite) begin
         n.hrdata = rd;
      end

      // Bus data phase writes
      if (r.dp_wr && r.dp_addr == mra_pkg::ADDR_CTRL) begin
         n.enable = hwdata[mra_pkg::CTRL_ENABLE];
         roll_set = roll_set | hwdata[mra_pkg::CTRL_END_LSB+:3];
      end
      if (r.dp_wr && in_reg(r.dp_addr, mra_pkg::ADDR_CFG, NCFG)) begin
         n.cfg[word_of(r.dp_addr, mra_pkg::ADDR_CFG)] = hwdata;
      end

      // Impulses waiting for conversion, saturating
      for (int i = 0; i < N0; i++) begin
         p = {2'b00, r.pend[i]};
         if (go0[i]) begin
            p = p - 10'h001;
         end
         if (r.in_s2[i] && !r.in_last[i]) begin
            p = p + 10'h001;
         end
         if (r.dp_wr && in_reg(r.dp_addr, mra_pkg::ADDR_SERIAL, N0) &&
               int'(word_of(r.dp_addr, mra_pkg::ADDR_SERIAL)) == i) begin
            p = p + {2'b00, hwdata[7:0]};
         end
         n.pend[i] = p > 10'h0FF ? 8'hFF : p[7:0];
      end

      // Processing steps
      n.l9_pulse = '0;
      case (r.state)
         ST_IDLE: begin
            if (r.roll != '0) begin
               n.state = ST_ROLL;
            end else if (r.enable && r.pend != '0) begin
               n.state = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            for (int x = 0; x < NR; x++) begin
               for (int f = 0; f < mra_pkg::N_PERIODS; f++) begin
                  n.res[x][f] = nv[x][f];
               end
               n.res[x][mra_pkg::F_CUMCUR] = nv[x][3];
            end
            for (int i = 0; i < N0; i++) begin
               if (go0[i]) begin
                  n.rem[i] = rem0[i];
               end
            end
            for (int q = 0; q < N9; q++) begin
               n.l9_pulse[q] = pass9[q] != '0;
            end
            n.res9 = nv9;
            n.rem9 = rem9n;
            n.state = ST_IDLE;
         end
         ST_ROLL: begin
            // Level 9 is left alone here
            for (int x = 0; x < NR; x++) begin
               for (int m = 0; m < mra_pkg::N_PERIODS; m++) begin
                  if (r.roll[m]) begin
                     n.res[x][mra_pkg::F_PREV+m] = r.res[x][m];
                     n.res[x][mra_pkg::F_CUM+m] =
                        r.res[x][mra_pkg::F_CUM+m] + r.res[x][m];
                     n.res[x][m] = '0;
                  end
               end
            end
            roll_clr = r.roll;
            n.state = ST_IDLE;
         end
         default: begin
            n.state = ST_IDLE;
         end
      endcase
      // A new period end in the clearing cycle is kept
      n.roll = (r.roll & ~roll_clr) | roll_set;
   end

   // ==================================================
   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
         r.hreadyout <= mra_pkg::RST_HREADYOUT;
      end else begin
         r <= n;
      end
   end

   assign hreadyout = r.hreadyout;
   assign hresp = r.hresp;
   assign hrdata = r.hrdata;
   assign l9_pulse = r.l9_pulse;
endmodule

// file: bench/mra_accumulator_checker.sv
`timescale 1ns/100ps
module mra_accumulator_checker #(
   parameter int N0 = 4,
   parameter int N1 = 2,
   parameter int N2 = 2,
   parameter int N9 = 2
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Pins
   input wire logic [N0-1:0] in_pulse,
   input wire logic [mra_pkg::N_PERIODS-1:0] period_end,
   input wire logic [N9-1:0] l9_pulse
);
   // ==================================================
   // Accepted reads
   logic rd_go;
   assign rd_go = hsel & htrans[1] & hready & ~hwrite;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence rd_at(a);
      rd_go && haddr == a;
   endsequence
   // ==================================================
   // Properties
   chk_ready_high: assert property (hreadyout)
      else $error("hreadyout dropped");
   chk_resp_okay: assert property (!hresp)
      else $error("error response seen");
   chk_rdata_hold: assert property (!rd_go |=> $stable(hrdata))
      else $error("read data moved without a read");
   chk_unmapped_zero: assert property (rd_at(12'hFFC) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_field_count: assert property (rd_at(12'h428) |=> hrdata == 32'h0)
      else $error("field beyond the tenth not zero");
   chk_end_bits_zero: assert property (
      rd_at(mra_pkg::ADDR_CTRL) |=> hrdata[6:4] == 3'h0)
      else $error("period end bits read back nonzero");
   chk_serial_width: assert property (
      rd_at(mra_pkg::ADDR_SERIAL) |=> hrdata[31:8] == 24'h0)
      else $error("pending count wider than a byte");
   chk_l9_single: assert property (l9_pulse != '0 |=> l9_pulse == '0)
      else $error("output strobe longer than one cycle");
endmodule
bind mra_accumulator mra_accumulator_checker #(.N0(N0), .N1(N1), .N2(N2),
   .N9(N9)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .in_pulse(in_pulse), .period_end(period_end),
   .l9_pulse(l9_pulse));

// file: bench/mra_meter_model.sv
`timescale 1ns/100ps
module mra_meter_model #(
   parameter int N = 4
) (
   // Clock
   input wire logic hclk,
   // Impulse lines
   output logic [N-1:0] pulse
);
   initial pulse = '0;
   // Each impulse is a level held long enough for the pin synchroniser
   task automatic send(input int i, input int n);
      repeat (n) begin
         @(posedge hclk);
         pulse[i] <= 1'b1;
         repeat (4) @(posedge hclk);
         pulse[i] <= 1'b0;
         repeat (4) @(posedge hclk);
      end
   endtask
endmodule

// file: bench/mra_accumulator_test.sv
`timescale 1ns/100ps
module mra_accumulator_test;
   // ==================================================
   // Signals
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [3:0] in_pulse;
   logic [2:0] period_end;
   logic [1:0] l9_pulse;
   int n_errors, checks, n_l9;
   // Sign, type and expected total for each filter step
   logic [35:0] ft [10] = '{36'hD00000000, 36'hE3B9AC9FF, 36'h600000000,
      36'hA00000000, 36'hC7FFFFFFF, 36'h400000000, 36'hBFFFFFFFF,
      36'h0FFFFFFFF, 36'h9FFFFFFFF, 36'h100000000};
   assign hready = hreadyout;
   mra_accumulator u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .in_pulse(in_pulse),
      .period_end(period_end), .l9_pulse(l9_pulse));
   mra_meter_model u_meter (.hclk(hclk), .pulse(in_pulse));
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      if (l9_pulse[0] === 1'b1) n_l9++;
   end
   // ==================================================
   // Tasks
   task automatic print_verdict;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      if (hready !== 1'b1) begin
         n_errors++;
         print_verdict();
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= mra_pkg::HSIZE_WORD;
      wrdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wrdy();
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      check($sformatf("reg %h", a), rd, e);
   endtask
   task automatic wcfg(input int w, input logic [31:0] d);
      xfer(1'b1, mra_pkg::ADDR_CFG + 12'(4 * w), d);
   endtask
   function automatic logic [11:0] ra(input int x, input int f);
      return mra_pkg::ADDR_RES + 12'(64 * x + 4 * f);
   endfunction
   task automatic idle;
      int k;
      repeat (6) @(posedge hclk);
      k = 0;
      do begin
         xfer(1'b0, mra_pkg::ADDR_STATUS, 32'h0);
         k++;
      end while ((rd & 32'h171) !== 32'h0 && k < 40);
      if ((rd & 32'h171) !== 32'h0) begin
         n_errors++;
         print_verdict();
      end
   endtask
   task automatic pend(input int i);
      @(posedge hclk);
      period_end[i] <= 1'b1;
      repeat (4) @(posedge hclk);
      period_end[i] <= 1'b0;
      idle();
   endtask
   // ==================================================
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = mra_pkg::HSIZE_WORD;
      hwdata = 32'h0;
      period_end = 3'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk(mra_pkg::ADDR_CTRL, 32'h0);
      rdchk(mra_pkg::ADDR_CFG, 32'h0);
      rdchk(12'hFFC, 32'h0);
      rdchk(ra(0, 10), 32'h0);
      wcfg(0, 32'h00060005);
      wcfg(1, 32'h00000001);
      wcfg(2, 32'h00020007);
      wcfg(3, 32'h00000103);
      wcfg(4, 32'h00010001);
      wcfg(6, 32'h00010001);
      wcfg(7, 32'h00000101);
      wcfg(8, 32'h00000003);
      wcfg(9, 32'h00000003);
      wcfg(12, 32'h00010001);
      wcfg(13, 32'h00010002);
      wcfg(14, 32'h00030400);
      wcfg(18, 32'h00020001);
      wcfg(19, 32'h00010000);
      rdchk(mra_pkg::ADDR_CFG + 12'h04C, 32'h00010000);
      xfer(1'b1, mra_pkg::ADDR_CTRL, 32'h1);
      xfer(1'b1, mra_pkg::ADDR_SERIAL + 12'h004, 32'h3);
      u_meter.send(0, 8);
      u_meter.send(3, 2);
      idle();
      rdchk(mra_pkg::ADDR_SERIAL, 32'h0);
      for (int f = 0; f < 10; f++) begin
         rdchk(ra(0, f), (f < 3 || f == 9) ? 32'h6 : 32'h0);
      end
      rdchk(ra(1, 9), 32'hFFFFFFF6);
      rdchk(ra(3, 9), 32'h0);
      rdchk(ra(4, 9), 32'hFFFFFFFC);
      rdchk(ra(6, 9), 32'hFFFFFFFE);
      rdchk(mra_pkg::ADDR_RES9, 32'h3);
      check("strobes", n_l9, 32'h3);
      pend(0);
      rdchk(ra(0, 0), 32'h0);
      rdchk(ra(0, 3), 32'h6);
      rdchk(ra(0, 6), 32'h6);
      rdchk(ra(0, 1), 32'h6);
      rdchk(ra(4, 3), 32'hFFFFFFFC);
      xfer(1'b1, mra_pkg::ADDR_CTRL, 32'h21);
      idle();
      rdchk(ra(0, 1), 32'h0);
      rdchk(ra(0, 4), 32'h6);
      rdchk(ra(0, 7), 32'h6);
      rdchk(ra(0, 3), 32'h6);
      rdchk(mra_pkg::ADDR_RES9, 32'h3);
      u_meter.send(0, 4);
      idle();
      rdchk(ra(0, 0), 32'h4);
      rdchk(ra(0, 2), 32'hA);
      rdchk(ra(0, 9), 32'hA);
      xfer(1'b1, mra_pkg::ADDR_CTRL, 32'h11);
      idle();
      rdchk(ra(0, 3), 32'h4);
      rdchk(ra(0, 6), 32'hA);
      rdchk(ra(0, 0), 32'h0);
      rdchk(mra_pkg::ADDR_RES9, 32'h5);
      check("strobes", n_l9, 32'h5);
      pend(2);
      rdchk(ra(0, 5), 32'hA);
      rdchk(ra(0, 8), 32'hA);
      rdchk(ra(0, 2), 32'h0);
      rdchk(ra(0, 9), 32'hA);
      for (int i = 0; i < 10; i++) begin
         wcfg(5, {23'h0, ft[i][35], 5'h0, ft[i][34:32]});
         xfer(1'b1, mra_pkg::ADDR_SERIAL + 12'h008, 32'h1);
         idle();
         rdchk(ra(2, 9), ft[i][31:0]);
      end
      print_verdict();
   end
endmodule
